// [hw/msp_map.svh]
// Purpose: Address map, field positions and timing counts of the sync processor
// Assumes: Included by the design module and by the testbench
// Notes:   Definitions only
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH
// Register byte addresses
`define MSP_HCNT_LO   8'h00
`define MSP_HCNT_HI   8'h04
`define MSP_VCNT_LO   8'h08
`define MSP_VCNT_HI   8'h0C
`define MSP_THIRD_CONTROL_REG     8'h10
`define MSP_SYNC_CFG  8'h14
`define MSP_SOA_UP    8'h18
`define MSP_SOA_LO    8'h1C
`define MSP_VEC       8'h20
`define MSP_MSK       8'h24
`define MSP_CLR       8'h28
// Field positions
`define MSP_POL_BIT   7
`define MSP_HFO_EN    0
`define MSP_HFO_POL   2
`define MSP_DIVIDE_BY_TWO_SELECT  3
`define MSP_IRQ_SOA   3
`define MSP_IRQ_VEV   4
// Timing
`define MSP_CLK_NS      10
`define MSP_CLAMP_N_NS  500
`define MSP_CLAMP_W_NS  900
`define MSP_CLAMP_N_CYC ((`MSP_CLAMP_N_NS + `MSP_CLK_NS - 1) / `MSP_CLK_NS)
`define MSP_CLAMP_W_CYC ((`MSP_CLAMP_W_NS + `MSP_CLK_NS - 1) / `MSP_CLK_NS)
`define MSP_VSEP_MIN  7'h40
`define MSP_VPRE_LAST 6'h3F
`define MSP_H_SAT     9'h1FF
`define MSP_V_MAX     12'hFFF
`define MSP_DTICK_END 3'h7
`define MSP_DV_END_S  10'h1FF
`define MSP_DV_END_L  10'h3FF
`define MSP_DVW_S     10'h008
`define MSP_DVW_L     10'h010
`define MSP_ACC_MAX   16'h7FFF
`define MSP_ACC_MIN   16'h8001
// Bus answers and reset values
`define MSP_RESP_OK   2'h0
`define MSP_RESP_ERR  2'h2
`define MSP_CFG_RST   7'h00
`endif

// [hw/msp_pkg.sv]
// Purpose: Types of the sync processor
// Assumes: Map header gives all numbers used by logic
// Notes:   State of the block is one packed struct
package msp_pkg;
  typedef struct packed {
    logic       csync;   // Vertical taken from composite input
    logic       up_dis;  // Upper safe-area bound off
    logic       cws;     // Wide clamp
    logic       ces;     // Clamp on trailing edge
    logic       dvs;     // Dummy vertical long divide
    logic [1:0] dhs;     // Dummy horizontal select hi/lo
  } msp_cfg_t;

  typedef struct packed {
    logic        hraw_q, vraw_q, hp_q, vp_q, hfi_q;
    logic [15:0] hacc, vacc;
    logic        hneg, vneg;
    logic [8:0]  hcyc, hmeas;
    logic        nosync;
    logic [5:0]  vpre;
    logic [11:0] vcnt, hlat, vlat;
    logic [6:0]  sepw;
    logic        vsep;
    logic [2:0]  dtick;
    logic [5:0]  dh;
    logic [9:0]  dv;
    logic        dhs_o, dvs_o;
    logic [6:0]  clcnt;
    logic        clamp;
    logic [1:0]  bad;
    logic        tog, half_freq_output_pin;
    logic [3:0]  ctl3;
    msp_cfg_t    cfg;
    logic [7:0]  soa_up, soa_lo;
    logic [5:0]  vec, msk;
    logic        aw_ok, w_ok;
    logic [7:0]  awa, wd;
    logic        wstb, bvalid;
    logic [1:0]  bresp, rresp;
    logic        rvalid;
    logic [7:0]  rdata;
  } msp_state_t;
endpackage : msp_pkg

// [hw/msp_sync_proc.sv]
// Purpose: Monitor sync processor with AXI4-Lite register access
// Assumes: i_core_clk is the oscillator clock; sync inputs synchronous
// Notes:   Registers are 8 bits wide in the low byte of each word
// Behaviour
// R1: Sync polarity detected automatically, shown in bit 7 of count high bytes.
// R2: Source keeps sync pulses short enough for polarity detection to work.
// R3: Composite pulses of 64 clocks or more are taken as vertical sync.
// R4: Two 12-bit counters measure horizontal and vertical rate continuously.
// R5: Vertical event latches both counts into the count registers.
// R6: Vertical counter steps every 64 clocks; overflow bounds lowest rate.
// R7: Horizontal count resolution is one eighth of a clock period; code counts whole clocks, low three bits read zero.
// R8: Dummy horizontal period 64N clocks, width 8N; N by select code.
// R9: Dummy vertical divides by 512 or 1024, width 8 or 16 lines.
// R10: Clamp starts at leading or trailing sync edge by edge select.
// R11: Clamp width narrow or wide by width select.
// R12: Two consecutive out-of-window horizontal measurements raise safe-area flag.
// R13: No horizontal edge for 512 clocks raises safe-area flag.
// R14: Upper-bound disable leaves only lower bound and missing-sync checks.
// R15: Half-rate output enable passes horizontal input at same or half rate.
// R16: Divide-by-two toggles on each falling input edge.
// R17: Polarity bit inverts the half-rate output.
// R18: Vertical-event flag on every vertical pulse and counter overflow.
// R19: Six sources combine into one shared request.
// R20: Vector register shows which source requested; software reads it.
// R21: Cleared mask bit blocks its source.
// R22: Writing one to clear register clears that flag; zero does nothing.
// R23: Hardware sets a vector flag only when its mask bit is set.
// R24: Latched counts hold until the next vertical event.
// R25: In-window measurement resets the consecutive violation count.
`timescale 1ns/10ps
`include "msp_map.svh"

module msp_sync_proc
  import msp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_hin,
  input  wire logic              i_vin,
  input  wire logic              i_half_freq_input_pin,
  input  wire logic [3:0]        i_ext_irq,
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  output logic                   o_dummy_hsync,
  output logic                   o_dummy_vsync,
  output logic                   o_vsync_sep,
  output logic                   o_clamp,
  output logic                   o_half_freq_output_pin,
  output logic                   o_shared_irq_request
);

  msp_state_t s;
  msp_state_t next_s;

  // Event and decode terms shared by the state update and checks
  logic       hp, vp, hlead, htrail, vlead;
  logic       vtick, vovf, vertical_event_flag, soa_ev;
  logic       h_hi, h_lo, in_win;
  logic [5:0] irq_set, irq_clr;
  logic       wr_go, aw_take, w_take, ar_take;
  logic [2:0] dn;

  // Saturating polarity accumulator: +1 high, -1 low
  function automatic logic [15:0] acc_step(
      input logic [15:0] a, input logic lvl);
    if (lvl) begin
      acc_step = (a == `MSP_ACC_MAX) ? a : a + 16'h0001;
    end else begin
      acc_step = (a == `MSP_ACC_MIN) ? a : a - 16'h0001;
    end
  endfunction : acc_step

  // Dummy divider factor N per select code
  always_comb begin
    case (s.cfg.dhs) // see R8
      2'h0:    dn = 3'h4;
      2'h1:    dn = 3'h2;
      2'h2:    dn = 3'h3;
      default: dn = 3'h5;
    endcase
  end

  // Sync pulses normalised to active high
  always_comb begin
    hp     = i_hin ^ s.hneg;
    hlead  = hp & ~s.hp_q;
    htrail = ~hp & s.hp_q;
    // Composite mode uses separated vertical
    vp     = s.cfg.csync ? s.vsep : (i_vin ^ s.vneg);
    vlead  = vp & ~s.vp_q;
    vtick  = (s.vpre == `MSP_VPRE_LAST); // see R6
    vovf   = vtick && (s.vcnt == `MSP_V_MAX) && !vlead;
    vertical_event_flag = vlead | vovf; // see R18
  end

  // Safe-area window, in clocks: 8*upper and 8*(lower+1)
  always_comb begin
    // Period is the clock count plus the edge cycle itself
    h_hi   = !s.cfg.up_dis && // see R14
             (({3'h0, s.hcyc} + 12'h001) < {1'b0, s.soa_up, 3'h0}); // see R12
    h_lo   = (({3'h0, s.hcyc} + 12'h001) > ({1'b0, s.soa_lo, 3'h0} + 12'h008));
    in_win = !h_hi && !h_lo;
    soa_ev = (hlead && !in_win && s.bad == 2'h1) ||
             (!s.nosync && s.hcyc == `MSP_H_SAT && !hlead); // see R13
  end

  // Shared request sources; hardware sets only where unmasked
  always_comb begin
    irq_set = {i_ext_irq[3], vertical_event_flag, soa_ev, i_ext_irq[2:0]}; // see R19
    irq_set = irq_set & s.msk; // see R21 see R23
  end

  // Bus handshakes: one write and one read in flight
  always_comb begin
    o_s_axi_awready = !s.aw_ok && !s.bvalid;
    o_s_axi_wready  = !s.w_ok && !s.bvalid;
    o_s_axi_arready = !s.rvalid;
    aw_take = i_s_axi_awvalid && o_s_axi_awready;
    w_take  = i_s_axi_wvalid && o_s_axi_wready;
    ar_take = i_s_axi_arvalid && o_s_axi_arready;
    wr_go   = s.aw_ok && s.w_ok && !s.bvalid;
    irq_clr = (wr_go && s.wstb && s.awa == `MSP_CLR) ? s.wd[5:0] : 6'h00;
  end

  // Next state of the whole block
  always_comb begin
    next_s = s;
    next_s.hraw_q = i_hin;
    next_s.vraw_q = i_vin;
    next_s.hp_q   = hp;
    next_s.vp_q   = vp;
    next_s.hfi_q  = i_half_freq_input_pin;

    // Polarity: longer level per period is the idle level
    next_s.hacc = acc_step(s.hacc, i_hin);
    next_s.vacc = acc_step(s.vacc, i_vin);
    if (i_hin && !s.hraw_q) begin
      next_s.hneg = !s.hacc[15] && (s.hacc != 16'h0000); // see R1
      next_s.hacc = 16'h0000;
    end
    if (i_vin && !s.vraw_q) begin
      next_s.vneg = !s.vacc[15] && (s.vacc != 16'h0000); // see R1
      next_s.vacc = 16'h0000;
    end

    // Separator: wide pulses are vertical
    if (!hp) begin
      next_s.sepw = 7'h00;
      next_s.vsep = 1'b0;
    end else if (s.sepw != `MSP_VSEP_MIN) begin
      next_s.sepw = s.sepw + 7'h01;
    end
    if (hp && next_s.sepw == `MSP_VSEP_MIN) begin
      next_s.vsep = 1'b1; // see R3
    end

    // Horizontal period in clocks, reported in eighths
    if (hlead) begin
      next_s.hmeas  = (s.hcyc == `MSP_H_SAT) ? s.hcyc : s.hcyc + 9'h001; // see R4 see R7
      next_s.hcyc   = 9'h000;
      next_s.nosync = 1'b0;
    end else if (s.hcyc != `MSP_H_SAT) begin
      next_s.hcyc = s.hcyc + 9'h001;
    end else begin
      next_s.nosync = 1'b1;
    end

    // Consecutive out-of-window count
    if (hlead) begin
      if (in_win) begin
        next_s.bad = 2'h0; // see R25
      end else if (s.bad == 2'h1) begin
        next_s.bad = 2'h0;
      end else begin
        next_s.bad = 2'h1;
      end
    end

    // Vertical period in 64-clock steps
    next_s.vpre = vtick ? 6'h00 : s.vpre + 6'h01;
    if (vtick) begin
      next_s.vcnt = s.vcnt + 12'h001; // see R4
    end
    if (vlead) begin
      next_s.vcnt = 12'h000;
      next_s.vpre = 6'h00;
    end
    // Latched values only move on a vertical event
    if (vertical_event_flag) begin
      next_s.hlat = {s.hmeas, 3'h0}; // see R5 see R24
      next_s.vlat = vovf ? `MSP_V_MAX : s.vcnt;
    end

    // Dummy sync generator, tick every 8 clocks
    next_s.dtick = s.dtick + 3'h1;
    if (s.dtick == `MSP_DTICK_END) begin
      if (s.dh >= {dn, 3'h0} - 6'h01) begin
        next_s.dh = 6'h00;
        if (s.dv >= (s.cfg.dvs ? `MSP_DV_END_L : `MSP_DV_END_S)) begin // see R9
          next_s.dv = 10'h000;
        end else begin
          next_s.dv = s.dv + 10'h001;
        end
      end else begin
        next_s.dh = s.dh + 6'h01;
      end
    end
    next_s.dhs_o = (s.dh < {3'h0, dn}); // see R8
    next_s.dvs_o = (s.dv < (s.cfg.dvs ? `MSP_DVW_L : `MSP_DVW_S)); // see R9

    // Clamp pulse, restarted by the selected edge
    if (s.cfg.ces ? htrail : hlead) begin // see R10
      next_s.clamp = 1'b1;
      next_s.clcnt = s.cfg.cws ? 7'(`MSP_CLAMP_W_CYC - 1)
                               : 7'(`MSP_CLAMP_N_CYC - 1); // see R11
    end else if (s.clcnt != 7'h00) begin
      next_s.clcnt = s.clcnt - 7'h01;
    end else begin
      next_s.clamp = 1'b0;
    end

    // Half-rate horizontal output
    if (s.hfi_q && !i_half_freq_input_pin) begin
      next_s.tog = !s.tog; // see R16
    end
    next_s.half_freq_output_pin = s.ctl3[`MSP_HFO_EN] && // see R15
                 ((s.ctl3[`MSP_DIVIDE_BY_TWO_SELECT] ? s.tog : i_half_freq_input_pin)
                  ^ s.ctl3[`MSP_HFO_POL]); // see R17

    // Vector flags: a new event wins over a clear
    next_s.vec = (s.vec & ~irq_clr) | irq_set; // see R22 see R20

    // Write address and data taken in either order
    if (aw_take) begin
      next_s.aw_ok = 1'b1;
      next_s.awa   = i_s_axi_awaddr[7:0];
    end
    if (w_take) begin
      next_s.w_ok = 1'b1;
      next_s.wd   = i_s_axi_wdata[7:0];
      next_s.wstb = i_s_axi_wstrb[0];
    end
    if (s.bvalid && i_s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.aw_ok  = 1'b0;
      next_s.w_ok   = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `MSP_RESP_OK;
      case (s.awa)
        `MSP_THIRD_CONTROL_REG: begin
          if (s.wstb) next_s.ctl3 = s.wd[3:0];
        end
        `MSP_SYNC_CFG: begin
          if (s.wstb) next_s.cfg = s.wd[6:0];
        end
        `MSP_SOA_UP: begin
          if (s.wstb) next_s.soa_up = s.wd;
        end
        `MSP_SOA_LO: begin
          if (s.wstb) next_s.soa_lo = s.wd;
        end
        `MSP_MSK: begin
          if (s.wstb) next_s.msk = s.wd[5:0];
        end
        // Count and vector registers ignore writes; clear acts through irq_clr
        `MSP_HCNT_LO, `MSP_HCNT_HI, `MSP_VCNT_LO,
        `MSP_VCNT_HI, `MSP_VEC, `MSP_CLR: begin
          next_s.bresp = `MSP_RESP_OK;
        end
        default: next_s.bresp = `MSP_RESP_ERR;
      endcase
    end

    // Reads answer one cycle after the address is taken
    if (s.rvalid && i_s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `MSP_RESP_OK;
      next_s.rdata  = 8'h00;
      case (i_s_axi_araddr[7:0])
        `MSP_HCNT_LO:  next_s.rdata = s.hlat[7:0];
        `MSP_HCNT_HI:  next_s.rdata = {s.hneg, 3'h0, s.hlat[11:8]}; // see R1
        `MSP_VCNT_LO:  next_s.rdata = s.vlat[7:0];
        `MSP_VCNT_HI:  next_s.rdata = {s.vneg, 3'h0, s.vlat[11:8]};
        `MSP_THIRD_CONTROL_REG:    next_s.rdata = {4'h0, s.ctl3};
        `MSP_SYNC_CFG: next_s.rdata = {1'b0, s.cfg};
        `MSP_SOA_UP:   next_s.rdata = s.soa_up;
        `MSP_SOA_LO:   next_s.rdata = s.soa_lo;
        `MSP_VEC:      next_s.rdata = {2'h0, s.vec}; // see R20
        `MSP_MSK:      next_s.rdata = {2'h0, s.msk};
        `MSP_CLR:      next_s.rdata = 8'h00;
        default:       next_s.rresp = `MSP_RESP_ERR;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  always_comb begin
    o_s_axi_bvalid         = s.bvalid;
    o_s_axi_bresp          = s.bresp;
    o_s_axi_rvalid         = s.rvalid;
    o_s_axi_rresp          = s.rresp;
    o_s_axi_rdata          = {24'h00_0000, s.rdata};
    o_dummy_hsync          = s.dhs_o;
    o_dummy_vsync          = s.dvs_o;
    o_vsync_sep            = s.vsep;
    o_clamp                = s.clamp;
    o_half_freq_output_pin = s.half_freq_output_pin;
    o_shared_irq_request   = |s.vec; // see R19
  end

  // Checks
  localparam int CLN = `MSP_CLAMP_N_CYC;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_vec_masked_set: assert property ( // see R23
    ((s.vec & ~$past(s.vec)) & ~$past(s.msk)) == 6'h00)
    else $error("vector flag set while masked");

  chk_clear_write: assert property ( // see R22
    (irq_clr != 6'h00) |=> ((s.vec & $past(irq_clr & ~irq_set)) == 6'h00))
    else $error("written clear did not clear flag");

  chk_vertical_event_flag_latch: assert property ( // see R5
    (vlead && !vovf) |=> (s.vlat == $past(s.vcnt) && s.vcnt == 12'h000))
    else $error("vertical count not latched on event");

  chk_latch_hold: assert property ( // see R24
    !vertical_event_flag |=> $stable(s.hlat) && $stable(s.vlat))
    else $error("latched count moved without event");

  chk_vcnt_step: assert property ( // see R6
    (!vtick && !vlead) |=> $stable(s.vcnt))
    else $error("vertical counter moved off the 64 clock step");

  chk_clamp_narrow: assert property ( // see R11
    (hlead && !s.cfg.ces && !s.cfg.cws) |=> (o_clamp && s.clcnt == 7'(CLN - 1)))
    else $error("narrow clamp width wrong");

  chk_nosync_soa: assert property ( // see R13
    (s.hcyc == `MSP_H_SAT && !s.nosync && !hlead && s.msk[`MSP_IRQ_SOA])
    |=> s.vec[`MSP_IRQ_SOA] && s.nosync)
    else $error("missing sync not flagged");

  chk_half_toggle: assert property ( // see R16
    (s.hfi_q && !i_half_freq_input_pin) |=> (s.tog != $past(s.tog)))
    else $error("divider did not toggle on falling edge");

  chk_hfo_off: assert property ( // see R15
    !s.ctl3[`MSP_HFO_EN] |=> !o_half_freq_output_pin)
    else $error("half rate output active while disabled");

  chk_irq_line: assert property ( // see R19
    $rose(o_shared_irq_request) |-> $past(irq_set != 6'h00))
    else $error("request raised without a source");

endmodule : msp_sync_proc

// [tb/msp_sync_src.sv]
// Purpose: Video source model driving horizontal and vertical sync
// Assumes: Period and width in oscillator clocks, frame in lines
// Notes:   Both lines rest at their inactive level while stopped
`timescale 1ns/10ps
module msp_sync_src (
  input  wire logic       i_core_clk,
  input  wire logic       i_run,
  input  wire logic [9:0] i_hper,
  input  wire logic [7:0] i_hwid,
  input  wire logic [7:0] i_vlines,
  input  wire logic       i_pol_low,
  output logic            o_hin,
  output logic            o_vin
);
  logic [9:0] hc;
  logic [7:0] lc;
  // Dot and line position; restart on stop so frames begin clean
  always_ff @(posedge i_core_clk) begin
    if (!i_run) begin
      hc <= 10'h000;
      lc <= 8'h00;
    end else if (hc == i_hper - 10'h001) begin
      hc <= 10'h000;
      lc <= (lc == i_vlines - 8'h01) ? 8'h00 : lc + 8'h01;
    end else begin
      hc <= hc + 10'h001;
    end
  end
  // Pulses stay well under the polarity detector limits
  assign o_hin = i_run ? ((hc < i_hwid) ^ i_pol_low) : i_pol_low;
  assign o_vin = i_run ? ((lc < 8'h02) ^ i_pol_low) : i_pol_low;
endmodule : msp_sync_src

// [tb/tb_monitor_sync_processor.sv]
// Purpose: Self-checking bench of the sync processor
// Assumes: Registers over AXI4-Lite; source model drives sync inputs
// Notes:   Register data from a shift register seeded with 41
`timescale 1ns/10ps
`include "msp_map.svh"
`define CHK_EQ(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_monitor_sync_processor;
  logic        clk, rst, run, pol, man_h, half_freq_input_pin, hin, hin_s, vin, prev;
  logic        awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv;
  logic        dh, dvs, vsep, clamp, half_freq_output_pin, irq;
  int          dvh, dvt;
  logic [3:0]  ext, ws;
  logic [7:0]  aw, ar, rd, lfsr;
  logic [31:0] wd, rdata;
  logic [1:0]  bresp, rresp, rs;
  int          fail_count, cmp_count, k, n, t, hi, per;
  int          dn [4] = '{4, 2, 3, 5};
  int          ib [4] = '{0, 1, 2, 5};
  int          he [4] = '{0, 20, 20, 10};
  logic [7:0]  hv [4] = '{8'h00, 8'h01, 8'h05, 8'h09};

  // Source: 200-clock lines, 20-clock pulses, 20-line frames
  msp_sync_src SRC (.i_core_clk(clk), .i_run(run), .i_hper(10'h0C8), .i_hwid(8'h14),
    .i_vlines(8'h14), .i_pol_low(pol), .o_hin(hin_s), .o_vin(vin));
  assign hin = run ? hin_s : man_h;

  msp_sync_proc DUT (.i_core_clk(clk), .i_rst(rst), .i_hin(hin), .i_vin(vin),
    .i_half_freq_input_pin(half_freq_input_pin), .i_ext_irq(ext), .i_s_axi_awaddr(aw),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bry), .i_s_axi_araddr(ar), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_dummy_hsync(dh), .o_dummy_vsync(dvs),
    .o_vsync_sep(vsep), .o_clamp(clamp), .o_half_freq_output_pin(half_freq_output_pin),
    .o_shared_irq_request(irq));

  // Oscillator, 10 ns period
  initial clk = 1'b0;
  always #5 clk = ~clk;

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  function automatic logic in_rng(input logic signed [31:0] v, input int lo, input int hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_rng

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic a_hs, w_hs, b_hs;
    @(posedge clk);
    aw <= a;
    wd <= {24'h00_0000, d};
    {awv, wv, bry} <= 3'h7;
    for (int c = 0; c < 64; c++) begin
      // Judge handshakes on settled values, act on them at the next edge
      @(negedge clk);
      a_hs = awv && awr;
      w_hs = wv && wrd;
      b_hs = bv;
      r    = bresp;
      @(posedge clk);
      if (a_hs) awv <= 1'b0;
      if (w_hs) wv <= 1'b0;
      if (b_hs) begin
        bry <= 1'b0;
        return;
      end
    end
    fail_count++;
    conclude();
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    logic a_hs, r_hs;
    @(posedge clk);
    ar <= a;
    {arv, rry} <= 2'h3;
    for (int c = 0; c < 64; c++) begin
      @(negedge clk);
      a_hs = arv && arr;
      r_hs = rv;
      d    = rdata[7:0];
      r    = rresp;
      @(posedge clk);
      if (a_hs) arv <= 1'b0;
      if (r_hs) begin
        rry <= 1'b0;
        return;
      end
    end
    fail_count++;
    conclude();
  endtask : rdr

  // High time and rise-to-rise period of one whole pulse
  task automatic meas(ref logic s, output int h, output int p);
    int c;
    for (c = 0; c < 3000 && s !== 1'b0; c++) @(negedge clk);
    for (; c < 3000 && s !== 1'b1; c++) @(negedge clk);
    for (h = 0; c < 3000 && s === 1'b1; c++, h++) @(negedge clk);
    for (p = h; c < 3000 && s !== 1'b1; c++, p++) @(negedge clk);
    if (c >= 3000) begin
      fail_count++;
      conclude();
    end
  endtask : meas

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ext <= m;
    @(posedge clk);
    ext <= 4'h0;
  endtask : pulse

  // Run is cut short if anything hangs
  initial begin
    #900_000;
    fail_count++;
    conclude();
  end

  // Dummy vertical: first pulse after reset spans 8 lines of 256 clocks
  initial begin
    dvh = 0;
    @(negedge rst);
    for (dvt = 0; dvt < 3000 && (dvh == 0 || dvs === 1'b1); dvt++) begin
      @(negedge clk);
      dvh += (dvs === 1'b1);
    end
    `CHK_EQ(dvh, 8 * 8 * 4 * 8);
  end

  initial begin
    {rst, run, pol, man_h, half_freq_input_pin, awv, wv, bry, arv, rry} = 10'h200;
    {ext, ws, aw, ar, wd} = {4'h0, 4'hF, 48'h0000_0000_0000};
    lfsr = 8'h29;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset state, unmapped place, read-only vector
    rdr(`MSP_MSK, rd, rs);
    `CHK_EQ(rd, 8'h00);
    rdr(8'h40, rd, rs);
    `CHK_EQ(rs, `MSP_RESP_ERR);
    wr(`MSP_VEC, 8'hFF, rs);
    rdr(`MSP_VEC, rd, rs);
    `CHK_EQ(rd, 8'h00);
    for (k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      wr(`MSP_SOA_LO, lfsr, rs);
      rdr(`MSP_SOA_LO, rd, rs);
      `CHK_EQ(rd, lfsr);
    end
    // Shared flags: masked, set, zero-write, one-write
    pulse(4'hF);
    rdr(`MSP_VEC, rd, rs);
    `CHK_EQ(rd, 8'h00);
    wr(`MSP_MSK, 8'h27, rs);
    for (k = 0; k < 4; k++) begin
      pulse(4'h1 << k);
      rdr(`MSP_VEC, rd, rs);
      `CHK_EQ(rd, 8'h01 << ib[k]);
      `CHK_EQ(irq, 1'b1);
      wr(`MSP_CLR, 8'h00, rs);
      rdr(`MSP_VEC, rd, rs);
      `CHK_EQ(rd, 8'h01 << ib[k]);
      wr(`MSP_CLR, 8'h01 << ib[k], rs);
      rdr(`MSP_VEC, rd, rs);
      `CHK_EQ(rd, 8'h00);
      `CHK_EQ(irq, 1'b0);
    end
    // Off, same rate in both polarities, half rate non-inverted
    for (k = 0; k < 4; k++) begin
      wr(`MSP_THIRD_CONTROL_REG, hv[k], rs);
      n = 0;
      prev = half_freq_output_pin;
      for (t = 0; t < 400; t++) begin
        @(posedge clk);
        half_freq_input_pin <= (t % 20) < 10;
        @(negedge clk);
        n += (half_freq_output_pin === 1'b1 && prev !== 1'b1);
        prev = half_freq_output_pin;
      end
      `CHK_EQ(in_rng(n, he[k] - (he[k] != 0), he[k] + (he[k] != 0)), 1'b1);
      repeat (8) @(posedge clk);
      if (!hv[k][3]) `CHK_EQ(half_freq_output_pin, hv[k][2]);
    end
    // Dummy horizontal for every select code
    for (k = 0; k < 4; k++) begin
      wr(`MSP_SYNC_CFG, k[7:0], rs);
      meas(dh, hi, per);
      meas(dh, hi, per);
      `CHK_EQ(hi, 8 * dn[k]);
      `CHK_EQ(per, 64 * dn[k]);
    end
    // Composite: 40-clock pulse is line sync, 100-clock pulse is frame sync
    wr(`MSP_SYNC_CFG, 8'h40, rs);
    for (k = 0; k < 2; k++) begin
      n = -1;
      for (t = 0; t < 200; t++) begin
        @(posedge clk);
        man_h <= (t < (k ? 100 : 40));
        @(negedge clk);
        if (vsep === 1'b1 && n < 0) n = t;
      end
      `CHK_EQ(in_rng(n, k ? 64 : -1, k ? 70 : -1), 1'b1);
    end
    // Counts latched at frame event, both sync polarities
    wr(`MSP_MSK, 8'h18, rs);
    wr(`MSP_SYNC_CFG, 8'h00, rs);
    for (k = 1; k >= 0; k--) begin
      pol <= k[0];
      run <= 1'b1;
      repeat (9000) @(posedge clk);
      wr(`MSP_CLR, 8'h10, rs);
      rd = 8'h00;
      for (n = 0; n < 3000 && rd[4] !== 1'b1; n++) rdr(`MSP_VEC, rd, rs);
      `CHK_EQ(rd[4], 1'b1);
      rdr(`MSP_HCNT_LO, rd, rs);
      `CHK_EQ(rd, 8'h40);
      rdr(`MSP_HCNT_HI, rd, rs);
      `CHK_EQ(rd, {k[0], 7'h06});
      rdr(`MSP_VCNT_LO, rd, rs);
      `CHK_EQ(in_rng(rd, 62, 63), 1'b1);
      rdr(`MSP_VCNT_HI, rd, rs);
      `CHK_EQ(rd, {k[0], 7'h00});
    end
    // Clamp start edge and width
    for (k = 0; k < 4; k++) begin
      wr(`MSP_SYNC_CFG, 8'(k << 3), rs);
      meas(clamp, hi, per);
      `CHK_EQ(in_rng(hi, k[1] ? 90 : 50, k[1] ? 100 : 60), 1'b1);
      for (t = 0; t < 400 && hin !== 1'b0; t++) @(negedge clk);
      for (; t < 400 && hin !== 1'b1; t++) @(negedge clk);
      for (n = 0; n < 400 && clamp !== 1'b1; n++) @(negedge clk);
      `CHK_EQ(in_rng(n, k[0] ? 19 : 0, k[0] ? 25 : 5), 1'b1);
    end
    // Window 240..808 clocks against a 200-clock line
    wr(`MSP_SOA_UP, 8'h1E, rs);
    wr(`MSP_SOA_LO, 8'h64, rs);
    for (k = 0; k < 2; k++) begin
      wr(`MSP_SYNC_CFG, k ? 8'h20 : 8'h00, rs);
      wr(`MSP_CLR, 8'h08, rs);
      repeat (600) @(posedge clk);
      rdr(`MSP_VEC, rd, rs);
      `CHK_EQ(rd[3], ~k[0]);
    end
    // Lines stop: missing sync still flagged with upper bound off
    run <= 1'b0;
    wr(`MSP_CLR, 8'h08, rs);
    repeat (700) @(posedge clk);
    rdr(`MSP_VEC, rd, rs);
    `CHK_EQ(rd[3], 1'b1);
    conclude();
  end
endmodule : tb_monitor_sync_processor
